// ---- verilog/cfsp_regs.sv ----
/*
  programmer-visible core registers: accumulator, two index registers,
  program counter, flags and stack pointer, with interrupt and call frames.
  assumes the instruction decoder drives one-cycle strobes and a memory
  that accepts one stack byte per cycle and returns pop data next cycle.
*/
`default_nettype none
`include "cfsp_cfg.svh"
module cfsp_regs #(
  parameter int unsigned IRQ_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire cfsp_pkg::cfsp_op_t flag_op_i,
  input wire logic [7:0] result_i,
  input wire logic carry_i,
  input wire logic half_i,
  input wire logic carry_val_i,
  input wire logic acc_we_i,
  input wire logic [7:0] acc_d_i,
  input wire logic idx1_we_i,
  input wire logic [7:0] idx1_d_i,
  input wire logic idx2_we_i,
  input wire logic [7:0] idx2_d_i,
  input wire logic pc_we_i,
  input wire logic [15:0] pc_d_i,
  input wire logic flags_we_i,
  input wire logic [7:0] flags_d_i,
  input wire logic mask_set_instr_i,
  input wire logic unmask_instr_i,
  input wire logic interrupt_return_instr_i,
  input wire logic stack_pointer_reset_instr_i,
  input wire logic load_instr_i,
  input wire logic [7:0] load_data_i,
  input wire logic call_i,
  input wire logic ret_i,
  input wire logic trap_i,
  input wire logic instr_end_i,
  input wire logic [IRQ_W-1:0] irq_i,
  input wire logic [IRQ_W-1:0] irq_ack_i,
  input wire logic [7:0] pop_data_i,
  output logic [7:0] accumulator_o,
  output logic [7:0] index1_o,
  output logic [7:0] index2_o,
  output logic [15:0] program_counter_o,
  output logic [7:0] flags_register_o,
  output logic [15:0] stack_pointer_o,
  output logic [7:0] irq_pending_o,
  output logic stack_we_o,
  output logic stack_re_o,
  output logic [15:0] stack_addr_o,
  output logic [7:0] stack_wdata_o,
  output logic int_enter_o,
  output logic busy_o
);
  cfsp_pkg::cfsp_state_t state_q;
  logic [7:0] acc_q;
  logic [7:0] idx1_q;
  logic [7:0] idx2_q;
  logic [15:0] pc_q;
  logic [7:0] flags_q;
  logic [IRQ_W-1:0] pend_q;
  logic [2:0] cnt_q;
  logic [2:0] len_q;
  logic irq_frame_q;
  logic [15:0] sp;
  logic [15:0] pop_addr;
  logic push;
  logic pop;
  logic [7:0] push_byte;
  logic service;
  logic pop_valid_q;
  logic [2:0] pop_idx_q;
  logic [2:0] pop_req_idx_q;

  // byte of the frame at push position n
  function automatic logic [7:0] frame_byte(input logic [2:0] n, input logic [15:0] pc,
                                            input logic [7:0] x, input logic [7:0] a,
                                            input logic [7:0] f);
    unique case (n)
      3'h0: frame_byte = pc[7:0];
      3'h1: frame_byte = pc[15:8];
      3'h2: frame_byte = x;
      3'h3: frame_byte = a;
      default: frame_byte = f;
    endcase
  endfunction : frame_byte

  // a pending unmasked request or a trap starts service at instruction end
  assign service = instr_end_i && (trap_i || (!flags_q[`CFSP_FLG_MASK] && |pend_q));
  assign push = state_q == cfsp_pkg::CFSP_PUSH;
  assign pop = state_q == cfsp_pkg::CFSP_POP;
  assign push_byte = frame_byte(cnt_q, pc_q, idx1_q, acc_q, flags_q);

  cfsp_stack_ptr u_sp (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .push_i(push),
    .pop_i(pop),
    .sp_reset_i(stack_pointer_reset_instr_i),
    .load_i(load_instr_i),
    .load_data_i(load_data_i),
    .sp_o(sp),
    .pop_addr_o(pop_addr)
  );

  // frame sequencer: counts bytes of a push or pop frame
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_q <= cfsp_pkg::CFSP_IDLE;
      cnt_q <= 3'h0;
      len_q <= 3'h0;
      irq_frame_q <= 1'b0;
    end else begin
      unique case (state_q)
        cfsp_pkg::CFSP_IDLE: begin
          cnt_q <= 3'h0;
          if (service) begin
            state_q <= cfsp_pkg::CFSP_PUSH;
            len_q <= `CFSP_INT_FRAME;
            irq_frame_q <= 1'b1;
          end else if (call_i) begin
            state_q <= cfsp_pkg::CFSP_PUSH;
            len_q <= `CFSP_CALL_FRAME;
            irq_frame_q <= 1'b0;
          end else if (interrupt_return_instr_i) begin
            state_q <= cfsp_pkg::CFSP_POP;
            len_q <= `CFSP_INT_FRAME;
            irq_frame_q <= 1'b1;
          end else if (ret_i) begin
            state_q <= cfsp_pkg::CFSP_POP;
            len_q <= `CFSP_CALL_FRAME;
            irq_frame_q <= 1'b0;
          end
        end
        cfsp_pkg::CFSP_PUSH: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == len_q - 3'h1) begin
            state_q <= irq_frame_q ? cfsp_pkg::CFSP_VECT : cfsp_pkg::CFSP_IDLE;
          end
        end
        cfsp_pkg::CFSP_POP: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == len_q - 3'h1) begin
            state_q <= cfsp_pkg::CFSP_IDLE;
          end
        end
        cfsp_pkg::CFSP_VECT: begin
          state_q <= cfsp_pkg::CFSP_IDLE;
        end
        default: begin
          state_q <= cfsp_pkg::CFSP_IDLE;
        end
      endcase
    end
  end

  // pop data stands the cycle after the read strobe, so the frame index
  // travels with the strobe and is used one cycle later
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pop_valid_q <= 1'b0;
      pop_idx_q <= 3'h0;
      pop_req_idx_q <= 3'h0;
    end else begin
      pop_req_idx_q <= len_q - 3'h1 - cnt_q;
      pop_valid_q <= stack_re_o;
      pop_idx_q <= pop_req_idx_q;
    end
  end

  // stack memory port, registered
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      stack_we_o <= 1'b0;
      stack_re_o <= 1'b0;
      stack_addr_o <= `CFSP_SP_RESET;
      stack_wdata_o <= 8'h00;
    end else begin
      stack_we_o <= push;
      stack_re_o <= pop;
      stack_addr_o <= pop ? pop_addr : sp;
      stack_wdata_o <= push_byte;
    end
  end

  // request latches: kept while masked, set wins over acknowledge
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~irq_ack_i) | irq_i;
    end
  end

  // accumulator and first index: written or restored from the frame
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      acc_q <= 8'h00;
      idx1_q <= 8'h00;
    end else if (pop_valid_q && irq_frame_q && pop_idx_q == 3'h3) begin
      acc_q <= pop_data_i;
    end else if (pop_valid_q && irq_frame_q && pop_idx_q == 3'h2) begin
      idx1_q <= pop_data_i;
    end else begin
      if (acc_we_i) begin
        acc_q <= acc_d_i;
      end
      if (idx1_we_i) begin
        idx1_q <= idx1_d_i;
      end
    end
  end

  // second index is never part of a frame
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      idx2_q <= 8'h00;
    end else if (idx2_we_i) begin
      idx2_q <= idx2_d_i;
    end
  end

  // program counter bytes, pushed low then high, restored high then low
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pc_q <= 16'h0000;
    end else if (pop_valid_q && pop_idx_q == 3'h1) begin
      pc_q[15:8] <= pop_data_i;
    end else if (pop_valid_q && pop_idx_q == 3'h0) begin
      pc_q[7:0] <= pop_data_i;
    end else if (pc_we_i) begin
      pc_q <= pc_d_i;
    end
  end

  // flags: reset pattern, alu updates, mask control, frame restore
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      flags_q <= `CFSP_FLG_RESET;
    end else if (state_q == cfsp_pkg::CFSP_VECT) begin
      flags_q[`CFSP_FLG_MASK] <= 1'b1;
    end else if (pop_valid_q && irq_frame_q && pop_idx_q == 3'h4) begin
      flags_q <= pop_data_i | 8'he0;
      flags_q[`CFSP_FLG_MASK] <= 1'b0;
    end else if (flags_we_i) begin
      flags_q <= flags_d_i | 8'he0;
    end else begin
      if (mask_set_instr_i) begin
        flags_q[`CFSP_FLG_MASK] <= 1'b1;
      end else if (unmask_instr_i) begin
        flags_q[`CFSP_FLG_MASK] <= 1'b0;
      end
      unique case (flag_op_i)
        cfsp_pkg::CFSP_OP_ADD: begin
          flags_q[`CFSP_FLG_HALF] <= half_i;
          flags_q[`CFSP_FLG_NEG] <= result_i[7];
          flags_q[`CFSP_FLG_ZERO] <= result_i == 8'h00;
          flags_q[`CFSP_FLG_CARRY] <= carry_i;
        end
        cfsp_pkg::CFSP_OP_LOGIC: begin
          flags_q[`CFSP_FLG_NEG] <= result_i[7];
          flags_q[`CFSP_FLG_ZERO] <= result_i == 8'h00;
        end
        cfsp_pkg::CFSP_OP_CARRY: begin
          flags_q[`CFSP_FLG_CARRY] <= carry_val_i;
        end
        cfsp_pkg::CFSP_OP_SHIFT: begin
          flags_q[`CFSP_FLG_CARRY] <= carry_i;
          flags_q[`CFSP_FLG_NEG] <= result_i[7];
          flags_q[`CFSP_FLG_ZERO] <= result_i == 8'h00;
        end
        default: begin
          flags_q[`CFSP_FLG_CARRY] <= flags_q[`CFSP_FLG_CARRY];
        end
      endcase
    end
  end

  // registered copies of internal state
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      accumulator_o <= 8'h00;
      index1_o <= 8'h00;
      index2_o <= 8'h00;
      program_counter_o <= 16'h0000;
      flags_register_o <= `CFSP_FLG_RESET;
      stack_pointer_o <= `CFSP_SP_RESET;
      irq_pending_o <= 8'h00;
      int_enter_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      accumulator_o <= acc_q;
      index1_o <= idx1_q;
      index2_o <= idx2_q;
      program_counter_o <= pc_q;
      flags_register_o <= flags_q;
      stack_pointer_o <= sp;
      irq_pending_o <= 8'(pend_q);
      int_enter_o <= state_q == cfsp_pkg::CFSP_VECT;
      busy_o <= state_q != cfsp_pkg::CFSP_IDLE;
    end
  end
endmodule : cfsp_regs
`default_nettype wire

// ---- verilog/cfsp_cfg.svh ----
/*
  constants for the core register set: flag bit positions, reset values,
  stack bounds. assumes inclusion by bare name from design files.
*/
`ifndef CFSP_CFG_SVH
`define CFSP_CFG_SVH
`define CFSP_FLG_HALF 4
`define CFSP_FLG_MASK 3
`define CFSP_FLG_NEG 2
`define CFSP_FLG_ZERO 1
`define CFSP_FLG_CARRY 0
`define CFSP_FLG_RESET 8'he8
`define CFSP_SP_RESET 16'h017f
`define CFSP_SP_HIGH 9'h002
`define CFSP_SP_LOW_RESET 7'h7f
`define CFSP_INT_FRAME 3'h5
`define CFSP_CALL_FRAME 3'h2
`endif

// ---- verilog/cfsp_pkg.sv ----
/*
  types for the core register set.
  assumes cfsp_cfg.svh is compiled alongside.
*/
`default_nettype none
package cfsp_pkg;
  // one-hot sequencer states for stack frames
  typedef enum logic [3:0] {
    CFSP_IDLE = 4'h1,
    CFSP_PUSH = 4'h2,
    CFSP_POP = 4'h4,
    CFSP_VECT = 4'h8
  } cfsp_state_t;
  // kind of flag update requested by the executing instruction
  typedef enum logic [2:0] {
    CFSP_OP_NONE = 3'h0,
    CFSP_OP_ADD = 3'h1,
    CFSP_OP_LOGIC = 3'h2,
    CFSP_OP_CARRY = 3'h3,
    CFSP_OP_SHIFT = 3'h4
  } cfsp_op_t;
endpackage : cfsp_pkg
`default_nettype wire

// ---- verilog/cfsp_stack_ptr.sv ----
/*
  stack pointer with forced upper bits and seven-bit wrap.
  assumes the sequencer gives at most one of push, pop, reset, load per cycle.
*/
`default_nettype none
`include "cfsp_cfg.svh"
module cfsp_stack_ptr (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic sp_reset_i,
  input wire logic load_i,
  input wire logic [7:0] load_data_i,
  output logic [15:0] sp_o,
  output logic [15:0] pop_addr_o
);
  logic [6:0] sp_low_q;
  logic [6:0] sp_low_d;
  logic [6:0] sp_inc;

  // next free slot, pop reads one above; both wrap in 128 bytes
  assign sp_inc = sp_low_q + 7'h01;
  assign sp_o = {`CFSP_SP_HIGH, sp_low_q};
  assign pop_addr_o = {`CFSP_SP_HIGH, sp_inc};

  // pointer update priority: reset instr, load, push, pop
  always_comb begin
    sp_low_d = sp_low_q;
    if (sp_reset_i) begin
      sp_low_d = `CFSP_SP_LOW_RESET;
    end else if (load_i) begin
      sp_low_d = load_data_i[6:0];
    end else if (push_i) begin
      sp_low_d = sp_low_q - 7'h01;
    end else if (pop_i) begin
      sp_low_d = sp_inc;
    end
  end

  // low seven bits held, reset to top of stack
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sp_low_q <= `CFSP_SP_LOW_RESET;
    end else begin
      sp_low_q <= sp_low_d;
    end
  end
endmodule : cfsp_stack_ptr
`default_nettype wire

// ---- tb/cfsp_regs_sva.sv ----
/*
  port checks for cfsp_regs: flags, stack pointer and stack frames.
  assumes a bind to cfsp_regs, one clock and a sync active-low reset.
*/
`default_nettype none
module cfsp_regs_sva (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire cfsp_pkg::cfsp_op_t flag_op_i,
  input wire logic [7:0] result_i,
  input wire logic half_i,
  input wire logic mask_set_instr_i,
  input wire logic unmask_instr_i,
  input wire logic load_instr_i,
  input wire logic [7:0] load_data_i,
  input wire logic [7:0] flags_register_o,
  input wire logic [15:0] stack_pointer_o,
  input wire logic stack_we_o,
  input wire logic [15:0] stack_addr_o,
  input wire logic int_enter_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // an interrupt frame is five back-to-back stack writes
  sequence s_five;
    $rose(stack_we_o) ##0 stack_we_o [*5] ##1 !stack_we_o;
  endsequence
  property p_rst;
    $rose(rst_b_i) |-> {flags_register_o[7:5], flags_register_o[3]} == 4'hf;
  endproperty
  property p_high;
    stack_pointer_o[15:7] == 9'h002;
  endproperty
  property p_half;
    flag_op_i == cfsp_pkg::CFSP_OP_ADD |-> ##2 flags_register_o[4] == $past(half_i, 2);
  endproperty
  property p_nz;
    flag_op_i inside {cfsp_pkg::CFSP_OP_ADD, cfsp_pkg::CFSP_OP_LOGIC, cfsp_pkg::CFSP_OP_SHIFT}
      |-> ##2 flags_register_o[2] == ($past(result_i, 2) > 8'h7f)
      && flags_register_o[1] == ($past(result_i, 2) == 8'h00);
  endproperty
  property p_mask;
    mask_set_instr_i || unmask_instr_i |-> ##2 flags_register_o[3] == $past(mask_set_instr_i, 2);
  endproperty
  property p_load;
    load_instr_i |-> ##2 stack_pointer_o[6:0] == 7'($past(load_data_i, 2));
  endproperty
  property p_dec;
    stack_we_o && $past(stack_we_o) |-> stack_addr_o[6:0] == 7'($past(stack_addr_o) - 16'h1);
  endproperty
  property p_frame;
    s_five |-> int_enter_o;
  endproperty
  a_rst: assert property (p_rst) else $error("flags reset value");
  a_high: assert property (p_high) else $error("stack pointer upper bits");
  a_half: assert property (p_half) else $error("half carry");
  a_nz: assert property (p_nz) else $error("sign or zero flag");
  a_mask: assert property (p_mask) else $error("mask bit");
  a_load: assert property (p_load) else $error("stack pointer load");
  a_dec: assert property (p_dec) else $error("push address");
  a_frame: assert property (p_frame) else $error("interrupt frame");
endmodule : cfsp_regs_sva
`default_nettype wire

// ---- tb/cfsp_regs_tb.sv ----
/*
  self-checking bench for cfsp_regs: alu flags, registers, stack frames.
  assumes cfsp_pkg, cfsp_regs and cfsp_regs_sva are compiled before it.
*/
`default_nettype none
module cfsp_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_b_i = 1'b0, carry_i = 1'b0, half_i = 1'b0, carry_val_i = 1'b0;
  logic acc_we_i = 1'b0, idx1_we_i = 1'b0, idx2_we_i = 1'b0, pc_we_i = 1'b0, flags_we_i = 1'b0;
  logic mask_set_instr_i = 1'b0, unmask_instr_i = 1'b0, interrupt_return_instr_i = 1'b0;
  logic stack_pointer_reset_instr_i = 1'b0, load_instr_i = 1'b0, call_i = 1'b0, ret_i = 1'b0;
  logic trap_i = 1'b0, instr_end_i = 1'b0;
  logic [7:0] result_i = 8'h00, acc_d_i = 8'h00, idx1_d_i = 8'h00, idx2_d_i = 8'h00;
  logic [7:0] flags_d_i = 8'h00, load_data_i = 8'h00, pop_data_i = 8'h00, irq_i = 8'h00;
  logic [7:0] irq_ack_i = 8'h00;
  logic [15:0] pc_d_i = 16'h0000;
  cfsp_pkg::cfsp_op_t flag_op_i = cfsp_pkg::CFSP_OP_NONE;
  logic [7:0] accumulator_o, index1_o, index2_o, flags_register_o, irq_pending_o, stack_wdata_o;
  logic [15:0] program_counter_o, stack_pointer_o, stack_addr_o;
  logic stack_we_o, stack_re_o, int_enter_o, busy_o;
  int bad_count = 0;
  int checked = 0;
  int k;
  logic [7:0] mf = 8'he8;
  logic [7:0] ma, mx, my, r;
  logic [7:0] e [5];
  logic [7:0] mem [128];
  logic [15:0] mpc;
  logic [23:0] wq [$];
  cfsp_pkg::cfsp_op_t ops [4];

  cfsp_regs i_dut (.*);

  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  // stack memory: logs writes, answers a read one cycle later, else toggles
  always @(posedge clk_i) begin
    if (stack_we_o === 1'b1) begin
      mem[stack_addr_o[6:0]] <= stack_wdata_o;
      wq.push_back({stack_addr_o, stack_wdata_o});
    end
    pop_data_i <= (stack_re_o === 1'b1) ? mem[stack_addr_o[6:0]] : ~pop_data_i;
  end

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wait_n(input int c);
    repeat (c) @(negedge clk_i);
  endtask : wait_n

  // waits for the frame sequencer to go idle, bounded
  task automatic settle;
    int n;
    n = 0;
    wait_n(3);
    while (busy_o !== 1'b0 && n < 40) begin
      n++;
      wait_n(1);
    end
    if (n == 40) bad_count++;
    wait_n(2);
  endtask : settle

  // compares logged stack writes with the expected bytes downward from top
  task automatic frame(input int cnt, input logic [15:0] top);
    cmp(24'(wq.size()), 24'(cnt));
    for (int i = 0; i < cnt; i++) begin
      cmp(wq[i], {top - 16'(i), e[i]});
    end
    wq.delete();
  endtask : frame

  task automatic complete_run;
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // watchdog
  initial begin
    repeat (3000) @(posedge clk_i);
    bad_count++;
    complete_run;
  end

  // main sequence
  initial begin
    ops = '{cfsp_pkg::CFSP_OP_ADD, cfsp_pkg::CFSP_OP_LOGIC, cfsp_pkg::CFSP_OP_CARRY,
      cfsp_pkg::CFSP_OP_SHIFT};
    k = $urandom(32'h0ce4);
    wait_n(3);
    rst_b_i = 1'b1;
    cmp(24'(flags_register_o & 8'he8), 24'he8);
    cmp(24'(stack_pointer_o), 24'h017f);
    // random alu results, each followed by a mask change
    for (int i = 0; i < 40; i++) begin
      k = (i == 0) ? 0 : int'($urandom_range(3, 0));
      r = (i % 8 == 1) ? 8'h00 : 8'($urandom);
      flag_op_i = ops[k];
      {result_i, half_i, carry_i, carry_val_i} = {r, r[3], r[5], r[6]};
      if (k != 2) mf[2:1] = {r[7], r == 8'h00};
      if (k == 0) mf[4] = r[3];
      if (k != 1) mf[0] = (k == 2) ? r[6] : r[5];
      wait_n(1);
      flag_op_i = cfsp_pkg::CFSP_OP_NONE;
      {mask_set_instr_i, unmask_instr_i} = {r[1], !r[1]};
      mf[3] = r[1];
      wait_n(1);
      {mask_set_instr_i, unmask_instr_i} = 2'b00;
      wait_n(3);
      cmp(24'(flags_register_o), 24'(mf));
    end
    // load working registers and mask requests
    {ma, mx, my, r} = $urandom;
    mpc = 16'($urandom);
    {acc_d_i, idx1_d_i, idx2_d_i, pc_d_i} = {ma, mx, my, mpc};
    {acc_we_i, idx1_we_i, idx2_we_i, pc_we_i, mask_set_instr_i} = 5'h1f;
    wait_n(1);
    {acc_we_i, idx1_we_i, idx2_we_i, pc_we_i, mask_set_instr_i} = 5'h00;
    wait_n(3);
    cmp({accumulator_o, index1_o, index2_o}, {ma, mx, my});
    cmp(24'(program_counter_o), 24'(mpc));
    // a masked request stays pending and starts no frame
    {irq_i, instr_end_i} = 9'h009;
    wait_n(1);
    {irq_i, instr_end_i} = 9'h000;
    wait_n(4);
    cmp(24'({busy_o, irq_pending_o}), 24'h004);
    // unmask, then the next boundary enters the handler
    unmask_instr_i = 1'b1;
    mf[3] = 1'b0;
    wait_n(1);
    {unmask_instr_i, instr_end_i} = 2'b01;
    wait_n(1);
    instr_end_i = 1'b0;
    k = 0;
    while (int_enter_o !== 1'b1 && k < 20) begin
      k++;
      wait_n(1);
    end
    cmp(24'(k < 20), 24'h1);
    e = '{mpc[7:0], mpc[15:8], mx, ma, mf};
    irq_ack_i = 8'h04;
    wait_n(1);
    irq_ack_i = 8'h00;
    wait_n(2);
    frame(5, 16'h017f);
    cmp(24'({flags_register_o[3], stack_pointer_o}), 24'h1017a);
    // overwrite the accumulator, then return restores context and unmasks
    {acc_d_i, acc_we_i} = {~ma, 1'b1};
    wait_n(1);
    {acc_we_i, interrupt_return_instr_i} = 2'b01;
    wait_n(1);
    interrupt_return_instr_i = 1'b0;
    settle;
    cmp({accumulator_o, index1_o, index2_o}, {ma, mx, my});
    cmp({program_counter_o, flags_register_o}, {mpc, mf});
    cmp(24'(stack_pointer_o), 24'h017f);
    // call at the bottom of the stack wraps to the top, return wraps back
    {load_data_i, load_instr_i} = {8'h81, 1'b1};
    wait_n(1);
    {load_instr_i, call_i} = 2'b01;
    wait_n(1);
    call_i = 1'b0;
    settle;
    {e[0], e[1]} = {mpc[7:0], mpc[15:8]};
    frame(2, 16'h0101);
    cmp(24'(stack_pointer_o), 24'h017f);
    ret_i = 1'b1;
    wait_n(1);
    ret_i = 1'b0;
    settle;
    cmp({stack_pointer_o, program_counter_o[7:0]}, {16'h0101, mpc[7:0]});
    stack_pointer_reset_instr_i = 1'b1;
    wait_n(1);
    stack_pointer_reset_instr_i = 1'b0;
    wait_n(3);
    cmp(24'(stack_pointer_o), 24'h017f);
    // flags written with the mask bit set; a trap still enters and pushes them
    mf = 8'($urandom) | 8'he8;
    {flags_d_i, flags_we_i} = {mf, 1'b1};
    wait_n(1);
    {flags_we_i, trap_i, instr_end_i} = 3'b011;
    wait_n(1);
    {trap_i, instr_end_i} = 2'b00;
    settle;
    e = '{mpc[7:0], mpc[15:8], mx, ma, mf};
    frame(5, 16'h017f);
    cmp(24'(flags_register_o), 24'(mf));
    // request latched inside the handler, unmask there enters at once
    irq_i = 8'h10;
    wait_n(1);
    {irq_i, unmask_instr_i} = 9'h001;
    wait_n(1);
    {unmask_instr_i, instr_end_i} = 2'b01;
    wait_n(1);
    instr_end_i = 1'b0;
    settle;
    mf[3] = 1'b0;
    e[4] = mf;
    frame(5, 16'h017a);
    complete_run;
  end
endmodule : cfsp_regs_tb

bind cfsp_regs cfsp_regs_sva i_sva (.*);
`default_nettype wire
